// ### dv/cpu_svc_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// cpu service model
// ----------------------------------------
module cpu_svc_model
   import irq_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // controller side
   input wire logic svc_en,
   input wire logic irq_req,
   input wire logic [7:0] cpu_rdata,
   output reg_req_t svc_req
);
   // top of the stack and the 16-bit vector address the core uses on entry
   localparam logic [8:0] STACK_TOP = 9'h1FF;
   localparam logic [15:0] VEC_ADDR = 16'hFFF6;
   logic [1:0] step_ff;
   logic [8:0] sp_ff;
   logic [15:0] vec_ff;
   // enter, read flags, write them back, return; one assignment per signal per edge
   always @(posedge clock) begin
      if (rst || !svc_en) begin
         step_ff <= 2'h0;
         sp_ff <= STACK_TOP;
         vec_ff <= 16'h0000;
         svc_req <= '0;
      end else if (step_ff == 2'h0 && irq_req) begin
         step_ff <= 2'h1;
         sp_ff <= STACK_TOP - 9'h002;
         vec_ff <= VEC_ADDR;
         svc_req <= '{1'b0, 1'b1, IRQ_EVENT_FLAGS_ADDR, 8'h00};
      end else if (step_ff == 2'h2) begin
         step_ff <= 2'h3;
         svc_req <= '{1'b1, 1'b0, IRQ_EVENT_FLAGS_ADDR, cpu_rdata};
      end else if (step_ff == 2'h3) begin
         step_ff <= 2'h0;
         sp_ff <= sp_ff + 9'h002;
         svc_req <= '0;
      end else begin
         step_ff <= (step_ff == 2'h0) ? 2'h0 : step_ff + 2'h1;
         svc_req <= '0;
      end
   end
endmodule : cpu_svc_model

// ### dv/six_source_irq_controller_tb_top.sv
`timescale 1ns/100ps
module six_source_irq_controller_tb_top
   import irq_ctrl_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic timer_a_ovf = 1'b0;
   logic timer_b_ovf = 1'b0;
   logic svc_en = 1'b0;
   logic cnt_clr = 1'b0;
   reg_req_t bench_req = '0;
   reg_req_t svc_req;
   reg_req_t cpu_req;
   logic [7:0] cpu_rdata;
   logic irq_req;
   logic [7:0] tick_cnt [4];
   logic [7:0] en, ev, a;
   int failures = 0;
   int n_tests = 0;
   int cyc = 0;
   // the model owns the bus while it services
   assign cpu_req = svc_en ? svc_req : bench_req;
   six_source_irq_controller dut (.clock(clock), .rst(rst), .cpu_req(cpu_req),
      .cpu_rdata(cpu_rdata), .timer_a_ovf(timer_a_ovf), .timer_b_ovf(timer_b_ovf),
      .irq_req(irq_req));
   cpu_svc_model partner (.clock(clock), .rst(rst), .svc_en(svc_en), .irq_req(irq_req),
      .cpu_rdata(cpu_rdata), .svc_req(svc_req));
   // clock
   initial forever #12.5 clock = ~clock;
   // serviced flags per bit, and a hang limit well above the 33k cycle run
   always @(posedge clock) begin
      cyc <= cyc + 1;
      for (int b = 0; b < 4; b++) begin
         if (cnt_clr) tick_cnt[b] <= 8'h00;
         else if (svc_en && svc_req.wr) tick_cnt[b] <= tick_cnt[b] + 8'(svc_req.wdata[b]);
      end
      if (cyc == 60000) begin
         failures++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clock);
      bench_req <= '{1'b1, 1'b0, ad, d};
      @(posedge clock);
      bench_req.wr <= 1'b0;
   endtask : wr
   // read data lands one cycle after the strobe edge
   task automatic rd(input logic [7:0] ad, exp, m, input string what);
      @(posedge clock);
      bench_req <= '{1'b0, 1'b1, ad, 8'h00};
      @(posedge clock);
      bench_req.rd <= 1'b0;
      #1 chk8(what, exp & m, cpu_rdata & m);
   endtask : rd
   function automatic logic [7:0] exp_ticks(input int b);
      int div [4] = '{2097152, 32768, 4096, 1024};
      return 8'(32768 / div[b]);
   endfunction : exp_ticks
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(22348));
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      rd(IRQ_ENABLE_MASK_ADDR, IRQ_ENABLE_MASK_RST, 8'hFF, "en rst");
      rd(IRQ_EVENT_FLAGS_ADDR, IRQ_EVENT_FLAGS_RST, 8'hFF, "flag rst");
      for (int i = 0; i < 4; i++) begin
         en = (i == 0) ? 8'hFF : 8'($urandom);
         wr(IRQ_ENABLE_MASK_ADDR, en);
         rd(IRQ_ENABLE_MASK_ADDR, en & IMPL_MASK, 8'hFF, "enable");
         a = 8'($urandom);
         if (a == IRQ_ENABLE_MASK_ADDR || a == IRQ_EVENT_FLAGS_ADDR) a = 8'h15;
         wr(a, 8'hFF);
         rd(a, 8'h00, 8'hFF, "unmapped");
      end
      $display("test registers done");
      // ticks may set low flags here, so only timer bits are compared
      for (int i = 0; i < 6; i++) begin
         en = (i == 0) ? 8'h00 : 8'($urandom) & 8'h50;
         ev = (i == 0) ? 8'h50 : 8'($urandom) & 8'h50;
         wr(IRQ_ENABLE_MASK_ADDR, en);
         @(posedge clock);
         timer_a_ovf <= ev[TIMER_A_BIT];
         timer_b_ovf <= ev[TIMER_B_BIT];
         @(posedge clock);
         timer_a_ovf <= 1'b0;
         timer_b_ovf <= 1'b0;
         wr(IRQ_EVENT_FLAGS_ADDR, 8'h00);
         rd(IRQ_EVENT_FLAGS_ADDR, ev, 8'h50, "flag set");
         chk8("irq set", {7'h00, |(en & ev)}, {7'h00, irq_req});
         wr(IRQ_EVENT_FLAGS_ADDR, ev);
         rd(IRQ_EVENT_FLAGS_ADDR, 8'h00, 8'h50, "flag clr");
         chk8("irq clr", 8'h00, {7'h00, irq_req});
      end
      @(posedge clock);
      bench_req <= '{1'b1, 1'b0, IRQ_EVENT_FLAGS_ADDR, 8'h10};
      timer_b_ovf <= 1'b1;
      @(posedge clock);
      bench_req.wr <= 1'b0;
      timer_b_ovf <= 1'b0;
      rd(IRQ_EVENT_FLAGS_ADDR, 8'h10, 8'h50, "set wins");
      $display("test events done");
      wr(IRQ_ENABLE_MASK_ADDR, 8'h0F);
      svc_en <= 1'b1;
      repeat (100) @(posedge clock);
      cnt_clr <= 1'b1;
      @(posedge clock);
      cnt_clr <= 1'b0;
      repeat (32768) @(posedge clock);
      svc_en <= 1'b0;
      #1;
      for (int b = 0; b < 4; b++) chk8("ticks", exp_ticks(b), tick_cnt[b]);
      $display("test ticks done");
      // one timer a service: push, vector fetch, clear, pop
      wr(IRQ_ENABLE_MASK_ADDR, 8'h40);
      svc_en <= 1'b1;
      timer_a_ovf <= 1'b1;
      @(posedge clock);
      timer_a_ovf <= 1'b0;
      @(posedge clock);
      #1 chk8("stack push", 8'hFD, partner.sp_ff[7:0]);
      chk8("vector lo", 8'hF6, partner.vec_ff[7:0]);
      chk8("vector hi", 8'hFF, partner.vec_ff[15:8]);
      repeat (3) @(posedge clock);
      #1 chk8("stack pop", 8'hFF, partner.sp_ff[7:0]);
      chk8("irq served", 8'h00, {7'h00, irq_req});
      svc_en <= 1'b0;
      $display("test service done");
      complete_run();
   end
endmodule : six_source_irq_controller_tb_top

// ### rtl/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

   // ----------------------------------------------------------------
   // register map (cpu data space)
   // ----------------------------------------------------------------
   localparam logic [7:0] IRQ_ENABLE_MASK_ADDR = 8'h13;
   localparam logic [7:0] IRQ_EVENT_FLAGS_ADDR = 8'h14;
   localparam logic [7:0] IRQ_ENABLE_MASK_RST = 8'h00;
   localparam logic [7:0] IRQ_EVENT_FLAGS_RST = 8'h00;

   // ----------------------------------------------------------------
   // field positions, shared by enable and flag registers
   // ----------------------------------------------------------------
   localparam int TIMER_A_BIT = 6;
   localparam int TIMER_B_BIT = 4;
   localparam int DIV1024_BIT = 3;
   localparam int DIV4096_BIT = 2;
   localparam int DIV32768_BIT = 1;
   localparam int DIV2097152_BIT = 0;
   // reserved bits 7 and 5 read as zero and ignore writes
   localparam logic [7:0] IMPL_MASK = 8'h5F;

   // ----------------------------------------------------------------
   // timebase divider taps: divide by 2**(tap+1)
   // ----------------------------------------------------------------
   localparam int DIV_WIDTH = 21;
   localparam int TAP_DIV1024 = 9;
   localparam int TAP_DIV4096 = 11;
   localparam int TAP_DIV32768 = 14;
   localparam int TAP_DIV2097152 = 20;

   // ----------------------------------------------------------------
   // cpu register access group
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

endpackage : irq_ctrl_pkg

// ### rtl/six_source_irq_controller.sv
`timescale 1ns/100ps
// Contract
// - six sources, one level, no nesting
// - timer a and b overflow pulses
// - ticks at osc/1024, 4096, 32768, 2097152
// - event sets flag regardless of enable
// - enabled set flag raises cpu request
// - disabled flag readable, no request
// - enable bits 6,4,3,2,1,0; 7,5 reserved
// - flag bits same positions as enables
// - writing one clears a flag
module six_source_irq_controller
   import irq_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // cpu register access
   input wire reg_req_t cpu_req,
   output logic [7:0] cpu_rdata,
   // timer overflow events
   input wire logic timer_a_ovf,
   input wire logic timer_b_ovf,
   // request to cpu core
   output logic irq_req
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [DIV_WIDTH-1:0] div_ff;
   logic [DIV_WIDTH-1:0] nxt_div;
   logic [7:0] enable_ff;
   logic [7:0] nxt_enable;
   logic [7:0] flags_ff;
   logic [7:0] nxt_flags;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic irq_ff;
   logic nxt_irq;
   logic [7:0] events;
   logic [7:0] clr_mask;
   logic tick_1k;
   logic tick_4k;
   logic tick_32k;
   logic tick_2m;

   // ----------------------------------------------------------------
   // free-running timebase divider
   // ----------------------------------------------------------------
   always_comb begin
      nxt_div = div_ff + DIV_WIDTH'(1);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         div_ff <= '0;
      end else begin
         div_ff <= nxt_div;
      end
   end

   tick_tap #(.TAP(TAP_DIV1024)) u_tap_1k (.clock(clock), .rst(rst), .div_cnt(div_ff),
      .tick(tick_1k));
   tick_tap #(.TAP(TAP_DIV4096)) u_tap_4k (.clock(clock), .rst(rst), .div_cnt(div_ff),
      .tick(tick_4k));
   tick_tap #(.TAP(TAP_DIV32768)) u_tap_32k (.clock(clock), .rst(rst), .div_cnt(div_ff),
      .tick(tick_32k));
   tick_tap #(.TAP(TAP_DIV2097152)) u_tap_2m (.clock(clock), .rst(rst), .div_cnt(div_ff),
      .tick(tick_2m));

   // ----------------------------------------------------------------
   // event vector in register bit order
   // ----------------------------------------------------------------
   always_comb begin
      events = 8'h00;
      events[TIMER_A_BIT] = timer_a_ovf;
      events[TIMER_B_BIT] = timer_b_ovf;
      events[DIV1024_BIT] = tick_1k;
      events[DIV4096_BIT] = tick_4k;
      events[DIV32768_BIT] = tick_32k;
      events[DIV2097152_BIT] = tick_2m;
   end

   // ----------------------------------------------------------------
   // enable and flag registers, read data, request
   // ----------------------------------------------------------------
   // read data is registered so the output comes from a flop; the cpu
   // sees it one cycle after the read strobe
   always_comb begin
      nxt_enable = enable_ff;
      clr_mask = 8'h00;
      if (cpu_req.wr && cpu_req.addr == IRQ_ENABLE_MASK_ADDR) begin
         nxt_enable = cpu_req.wdata & IMPL_MASK;
      end
      if (cpu_req.wr && cpu_req.addr == IRQ_EVENT_FLAGS_ADDR) begin
         clr_mask = cpu_req.wdata & IMPL_MASK;
      end
      // set wins over clear; zero bits leave the flag alone
      nxt_flags = ((flags_ff & ~clr_mask) | events) & IMPL_MASK;
      // one level: any enabled flag, no ranking among sources
      nxt_irq = |(nxt_flags & nxt_enable);
      nxt_rdata = 8'h00;
      if (cpu_req.rd) begin
         case (cpu_req.addr)
            IRQ_ENABLE_MASK_ADDR: nxt_rdata = enable_ff;
            IRQ_EVENT_FLAGS_ADDR: nxt_rdata = flags_ff;
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         enable_ff <= IRQ_ENABLE_MASK_RST;
         flags_ff <= IRQ_EVENT_FLAGS_RST;
         rdata_ff <= 8'h00;
         irq_ff <= 1'b0;
      end else begin
         enable_ff <= nxt_enable;
         flags_ff <= nxt_flags;
         rdata_ff <= nxt_rdata;
         irq_ff <= nxt_irq;
      end
   end

   assign cpu_rdata = rdata_ff;
   assign irq_req = irq_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   flag_set_a: assert property (@(posedge clock) disable iff (rst)
      timer_a_ovf |=> flags_ff[TIMER_A_BIT])
      else $error("timer a event did not set its flag");

   set_wins_a: assert property (@(posedge clock) disable iff (rst)
      (timer_b_ovf && cpu_req.wr && cpu_req.addr == IRQ_EVENT_FLAGS_ADDR
       && cpu_req.wdata[TIMER_B_BIT]) |=> flags_ff[TIMER_B_BIT])
      else $error("clear beat a simultaneous event");

   w1c_clear_a: assert property (@(posedge clock) disable iff (rst)
      (cpu_req.wr && cpu_req.addr == IRQ_EVENT_FLAGS_ADDR && cpu_req.wdata[TIMER_A_BIT]
       && !timer_a_ovf) |=> !flags_ff[TIMER_A_BIT])
      else $error("writing one did not clear the flag");

   zero_keep_a: assert property (@(posedge clock) disable iff (rst)
      (flags_ff[TIMER_A_BIT] && cpu_req.wr && cpu_req.addr == IRQ_EVENT_FLAGS_ADDR
       && !cpu_req.wdata[TIMER_A_BIT]) |=> flags_ff[TIMER_A_BIT])
      else $error("writing zero changed a flag");

   irq_or_a: assert property (@(posedge clock) disable iff (rst)
      irq_req == |(flags_ff & enable_ff))
      else $error("request differs from enabled flags");

   masked_quiet_a: assert property (@(posedge clock) disable iff (rst)
      (enable_ff == 8'h00) |-> !irq_req)
      else $error("request raised with all sources disabled");

   reserved_zero_a: assert property (@(posedge clock) disable iff (rst)
      ((enable_ff | flags_ff) & ~IMPL_MASK) == 8'h00)
      else $error("reserved bit set");

   tick_period_a: assert property (@(posedge clock) disable iff (rst)
      tick_1k |=> !tick_1k [*8])
      else $error("divide-by-1024 tick repeated too soon");

   // no sampled-value function here, so the first clock of the run needs no history
   reset_clear_a: assert property (@(posedge clock)
      rst |=> (enable_ff == IRQ_ENABLE_MASK_RST && flags_ff == IRQ_EVENT_FLAGS_RST
               && !irq_req && cpu_rdata == 8'h00))
      else $error("state not cleared by reset");

   timer_b_set_a: assert property (@(posedge clock) disable iff (rst)
      timer_b_ovf |=> flags_ff[TIMER_B_BIT])
      else $error("timer b event did not set its flag");

   tick_flag_a: assert property (@(posedge clock) disable iff (rst)
      tick_1k |=> flags_ff[DIV1024_BIT])
      else $error("divide-by-1024 tick did not set its flag");

   en_write_a: assert property (@(posedge clock) disable iff (rst)
      (cpu_req.wr && cpu_req.addr == IRQ_ENABLE_MASK_ADDR)
      |=> enable_ff == ($past(cpu_req.wdata) & IMPL_MASK))
      else $error("enable write did not land");

   flag_read_a: assert property (@(posedge clock) disable iff (rst)
      (cpu_req.rd && cpu_req.addr == IRQ_EVENT_FLAGS_ADDR)
      |=> cpu_rdata == $past(flags_ff))
      else $error("flag read returned wrong data");

   rdata_idle_a: assert property (@(posedge clock) disable iff (rst)
      !cpu_req.rd |=> cpu_rdata == 8'h00)
      else $error("read data not idle without a read");

   // each tap must fire exactly where the divider wraps past its bit; a slip
   // here would stretch every timebase period without any flag looking wrong
   tick_1k_pos_a: assert property (@(posedge clock) disable iff (rst)
      tick_1k |-> div_ff[TAP_DIV1024:0] == '0)
      else $error("divide-by-1024 tick off its boundary");

   tick_4k_pos_a: assert property (@(posedge clock) disable iff (rst)
      tick_4k |-> div_ff[TAP_DIV4096:0] == '0)
      else $error("divide-by-4096 tick off its boundary");

   tick_32k_pos_a: assert property (@(posedge clock) disable iff (rst)
      tick_32k |-> div_ff[TAP_DIV32768:0] == '0)
      else $error("divide-by-32768 tick off its boundary");

   tick_2m_pos_a: assert property (@(posedge clock) disable iff (rst)
      tick_2m |-> div_ff[TAP_DIV2097152:0] == '0)
      else $error("divide-by-2097152 tick off its boundary");

   // the count of zero right after reset is not a boundary, so it is left out
   tick_1k_due_a: assert property (@(posedge clock) disable iff (rst)
      (div_ff[TAP_DIV1024:0] == '0 && div_ff != '0) |-> tick_1k)
      else $error("divide-by-1024 tick missing");

   tick_4k_due_a: assert property (@(posedge clock) disable iff (rst)
      (div_ff[TAP_DIV4096:0] == '0 && div_ff != '0) |-> tick_4k)
      else $error("divide-by-4096 tick missing");

   tick_32k_due_a: assert property (@(posedge clock) disable iff (rst)
      (div_ff[TAP_DIV32768:0] == '0 && div_ff != '0) |-> tick_32k)
      else $error("divide-by-32768 tick missing");

endmodule : six_source_irq_controller

// ### rtl/tick_tap.sv
`timescale 1ns/100ps
// one-cycle pulse when a divider bit falls, i.e. every 2**(tap+1) clocks
module tick_tap
   import irq_ctrl_pkg::*;
#(
   parameter int TAP = 0
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // divider state
   input wire logic [DIV_WIDTH-1:0] div_cnt,
   // tick out
   output logic tick
);

   logic prev_ff;
   logic nxt_prev;

   // ----------------------------------------------------------------
   // falling-edge detect on the selected divider bit
   // ----------------------------------------------------------------
   always_comb begin
      nxt_prev = div_cnt[TAP];
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= nxt_prev;
      end
   end

   assign tick = prev_ff & ~div_cnt[TAP];

endmodule : tick_tap
